/* rtl/mrx_exec_unit.sv */
// Execution unit for moves, OR, returns, rotates, subtract-with-borrow and decrement-skip
`timescale 1ns/1ps
`default_nettype none
module mrx_exec_unit (
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	input wire logic issue_i,
	input wire mrx_pkg::mrx_instr_t instr_i,
	input wire logic [mrx_pkg::DW-1:0] mem_rdata_i,
	input wire logic [mrx_pkg::PC_W-1:0] stack_top_i,
	input wire logic irq_en_clr_i,
	input wire logic sys_flags_we_i,
	input wire mrx_pkg::mrx_sysflags_t sys_flags_i,
	output logic ready_o,
	output logic [mrx_pkg::DW-1:0] work_o,
	output mrx_pkg::mrx_flags_t flags_o,
	output logic global_irq_enable_o,
	output logic [mrx_pkg::PC_W-1:0] pc_o,
	output logic mem_we_o,
	output logic [mrx_pkg::DW-1:0] mem_wdata_o,
	output logic stack_pop_o,
	output logic discard_o
);
	import mrx_pkg::*;

	mrx_state_t state_reg;
	logic [DW-1:0] work_reg;
	mrx_flags_t flags_reg;
	logic irq_en_reg;
	logic [PC_W-1:0] pc_reg;
	logic mem_we_reg;
	logic [DW-1:0] mem_wdata_reg;
	logic pop_reg;
	logic discard_reg;

	logic taken;
	logic [DW-1:0] m;
	logic cy;
	logic [DW-1:0] rot_l;
	logic [DW-1:0] rot_r;
	logic [DW-1:0] rot_lc;
	logic [DW-1:0] rot_rc;
	logic [DW-1:0] union_src;
	logic [DW-1:0] union_res;
	logic [DW:0] sub_full;
	logic [NIB:0] sub_low;
	logic [DW-1:0] sub_res;
	logic sub_wrap;
	logic [DW-1:0] dec_res;
	logic dec_zero;

	logic work_we;
	logic [DW-1:0] work_next;
	mrx_flags_t flags_next;
	logic mem_we_next;
	logic [DW-1:0] mem_wdata_next;
	logic pop_next;
	logic skip_next;
	logic irq_set_next;
	logic two_cycle;

	assign taken = issue_i && (state_reg == ST_RUN);
	assign ready_o = (state_reg == ST_RUN);
	assign m = mem_rdata_i;
	assign cy = flags_reg.arith_spill_flag;

	// Datapath results
	assign rot_l = {m[DW-2:0], m[DW-1]};
	assign rot_r = {m[0], m[DW-1:1]};
	assign rot_lc = {m[DW-2:0], cy};
	assign rot_rc = {cy, m[DW-1:1]};
	assign union_src = (instr_i.op == OP_UNION_IMM) ? instr_i.imm : m;
	assign union_res = work_reg | union_src;
	// Borrow is the inverse of the spill flag, so add the complement plus the flag
	assign sub_full = {1'b0, work_reg} + {1'b0, ~m} + {{DW{1'b0}}, cy};
	assign sub_low = {1'b0, work_reg[NIB-1:0]} + {1'b0, ~m[NIB-1:0]} + {{NIB{1'b0}}, cy};
	assign sub_res = sub_full[DW-1:0];
	assign sub_wrap = (work_reg[DW-1] != m[DW-1]) && (sub_res[DW-1] != work_reg[DW-1]);
	assign dec_res = m - DEC_STEP;
	assign dec_zero = (dec_res == ZERO_BYTE);

	always_comb begin
		work_we = 1'b0;
		work_next = work_reg;
		flags_next = flags_reg;
		mem_we_next = 1'b0;
		mem_wdata_next = mem_wdata_reg;
		pop_next = 1'b0;
		skip_next = 1'b0;
		irq_set_next = 1'b0;
		two_cycle = 1'b0;
		unique case (instr_i.op)
			OP_COPY_MEM_TO_WORK: begin
				work_we = 1'b1;
				work_next = m;
			end
			OP_COPY_IMM_TO_WORK: begin
				work_we = 1'b1;
				work_next = instr_i.imm;
			end
			OP_COPY_WORK_TO_MEM: begin
				mem_we_next = 1'b1;
				mem_wdata_next = work_reg;
			end
			OP_NO_OPERATION: begin
				work_we = 1'b0;
			end
			OP_UNION_MEM, OP_UNION_IMM: begin
				work_we = 1'b1;
				work_next = union_res;
				flags_next.result_null_flag = (union_res == ZERO_BYTE);
			end
			OP_UNION_TO_MEM: begin
				mem_we_next = 1'b1;
				mem_wdata_next = union_res;
				flags_next.result_null_flag = (union_res == ZERO_BYTE);
			end
			OP_BACK_FROM_CALL: begin
				pop_next = 1'b1;
				two_cycle = 1'b1;
			end
			OP_BACK_FROM_CALL_IMM: begin
				pop_next = 1'b1;
				two_cycle = 1'b1;
				work_we = 1'b1;
				work_next = instr_i.imm;
			end
			OP_BACK_FROM_IRQ: begin
				pop_next = 1'b1;
				two_cycle = 1'b1;
				irq_set_next = 1'b1;
			end
			OP_ROTL: begin
				mem_we_next = 1'b1;
				mem_wdata_next = rot_l;
			end
			OP_ROTL_WORK: begin
				work_we = 1'b1;
				work_next = rot_l;
			end
			OP_ROTL_CY: begin
				mem_we_next = 1'b1;
				mem_wdata_next = rot_lc;
				flags_next.arith_spill_flag = m[DW-1];
			end
			OP_ROTL_CY_WORK: begin
				work_we = 1'b1;
				work_next = rot_lc;
				flags_next.arith_spill_flag = m[DW-1];
			end
			OP_ROTR: begin
				mem_we_next = 1'b1;
				mem_wdata_next = rot_r;
			end
			OP_ROTR_WORK: begin
				work_we = 1'b1;
				work_next = rot_r;
			end
			OP_ROTR_CY: begin
				mem_we_next = 1'b1;
				mem_wdata_next = rot_rc;
				flags_next.arith_spill_flag = m[0];
			end
			OP_ROTR_CY_WORK: begin
				work_we = 1'b1;
				work_next = rot_rc;
				flags_next.arith_spill_flag = m[0];
			end
			OP_SUB_BORROW, OP_SUB_BORROW_MEM: begin
				flags_next.signed_wrap_flag = sub_wrap;
				flags_next.result_null_flag = (sub_res == ZERO_BYTE);
				flags_next.half_carry_flag = sub_low[NIB];
				flags_next.arith_spill_flag = sub_full[DW];
				if (instr_i.op == OP_SUB_BORROW) begin
					work_we = 1'b1;
					work_next = sub_res;
				end else begin
					mem_we_next = 1'b1;
					mem_wdata_next = sub_res;
				end
			end
			OP_DEC_SKIP_ZERO: begin
				mem_we_next = 1'b1;
				mem_wdata_next = dec_res;
				skip_next = dec_zero;
				two_cycle = dec_zero;
			end
			OP_DEC_SKIP_ZERO_WORK: begin
				work_we = 1'b1;
				work_next = dec_res;
				skip_next = dec_zero;
				two_cycle = dec_zero;
			end
			default: begin
				work_we = 1'b0;
			end
		endcase
	end

	// Sequencer: two-cycle work ends in a dummy cycle with no issue accepted
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state_reg <= ST_RUN;
		end else begin
			unique case (state_reg)
				ST_RUN: begin
					if (taken && two_cycle) begin
						state_reg <= ST_DUMMY;
					end
				end
				ST_DUMMY: begin
					state_reg <= ST_RUN;
				end
			endcase
		end
	end

	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			work_reg <= WORK_RST;
		end else if (taken && work_we) begin
			work_reg <= work_next;
		end
	end

	// Slice flags change only through the instruction, system flags only via their own port
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			flags_reg <= FLAGS_RST;
		end else begin
			if (taken) begin
				flags_reg.signed_wrap_flag <= flags_next.signed_wrap_flag;
				flags_reg.result_null_flag <= flags_next.result_null_flag;
				flags_reg.half_carry_flag <= flags_next.half_carry_flag;
				flags_reg.arith_spill_flag <= flags_next.arith_spill_flag;
			end
			if (sys_flags_we_i) begin
				flags_reg.watchdog_timeout_flag <= sys_flags_i.watchdog_timeout_flag;
				flags_reg.power_down_flag <= sys_flags_i.power_down_flag;
			end
		end
	end

	// Set by the interrupt return wins over a clear in the same cycle
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			irq_en_reg <= IRQ_EN_RST;
		end else if (taken && irq_set_next) begin
			irq_en_reg <= IRQ_EN_SET;
		end else if (irq_en_clr_i) begin
			irq_en_reg <= ~IRQ_EN_SET;
		end
	end

	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			pc_reg <= PC_RST;
		end else if (taken) begin
			if (pop_next) begin
				pc_reg <= stack_top_i;
			end else if (skip_next) begin
				pc_reg <= pc_reg + PC_SKIP_STEP;
			end else begin
				pc_reg <= pc_reg + PC_STEP;
			end
		end
	end

	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			mem_we_reg <= 1'b0;
			mem_wdata_reg <= ZERO_BYTE;
		end else begin
			mem_we_reg <= taken && mem_we_next;
			mem_wdata_reg <= taken ? mem_wdata_next : mem_wdata_reg;
		end
	end

	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			pop_reg <= 1'b0;
			discard_reg <= 1'b0;
		end else begin
			pop_reg <= taken && pop_next;
			discard_reg <= taken && skip_next;
		end
	end

	assign work_o = work_reg;
	assign flags_o = flags_reg;
	assign global_irq_enable_o = irq_en_reg;
	assign pc_o = pc_reg;
	assign mem_we_o = mem_we_reg;
	assign mem_wdata_o = mem_wdata_reg;
	assign stack_pop_o = pop_reg;
	assign discard_o = discard_reg;

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (sys_rst_i);

	property p_copy_mem;
		taken && instr_i.op == OP_COPY_MEM_TO_WORK |=> work_o == $past(mem_rdata_i)
			&& flags_o == $past(flags_o);
	endproperty
	a_copy_mem: assert property (p_copy_mem) else $error("copy to work wrong");

	property p_copy_imm;
		taken && instr_i.op == OP_COPY_IMM_TO_WORK |=> work_o == $past(instr_i.imm);
	endproperty
	a_copy_imm: assert property (p_copy_imm) else $error("immediate copy wrong");

	property p_copy_to_mem;
		taken && instr_i.op == OP_COPY_WORK_TO_MEM |=> mem_we_o
			&& mem_wdata_o == $past(work_o) && work_o == $past(work_o);
	endproperty
	a_copy_to_mem: assert property (p_copy_to_mem) else $error("store wrong");

	property p_nop;
		taken && instr_i.op == OP_NO_OPERATION |=> pc_o == $past(pc_o) + PC_STEP
			&& !mem_we_o && work_o == $past(work_o) && ready_o;
	endproperty
	a_nop: assert property (p_nop) else $error("no-operation changed state");

	property p_union;
		taken && instr_i.op == OP_UNION_MEM |=> work_o == ($past(work_o) | $past(mem_rdata_i))
			&& flags_o.result_null_flag == (work_o == ZERO_BYTE)
			&& flags_o.arith_spill_flag == $past(flags_o.arith_spill_flag);
	endproperty
	a_union: assert property (p_union) else $error("OR result wrong");

	property p_ret_two_cycle;
		taken && instr_i.op == OP_BACK_FROM_CALL |=> stack_pop_o && !ready_o
			&& pc_o == $past(stack_top_i) ##1 ready_o && !stack_pop_o;
	endproperty
	a_ret_two_cycle: assert property (p_ret_two_cycle) else $error("return timing wrong");

	property p_back_from_irq_enable;
		taken && instr_i.op == OP_BACK_FROM_IRQ |=> global_irq_enable_o
			##1 (global_irq_enable_o || $past(irq_en_clr_i));
	endproperty
	a_back_from_irq_enable: assert property (p_back_from_irq_enable) else $error("irq enable not set");

	property p_rotl_cy;
		taken && instr_i.op == OP_ROTL_CY |=> mem_we_o
			&& mem_wdata_o == {$past(mem_rdata_i[DW-2:0]), $past(flags_o.arith_spill_flag)}
			&& flags_o.arith_spill_flag == $past(mem_rdata_i[DW-1]);
	endproperty
	a_rotl_cy: assert property (p_rotl_cy) else $error("left carry rotate wrong");

	property p_rotr;
		taken && instr_i.op == OP_ROTR |=> mem_wdata_o == {$past(mem_rdata_i[0]),
			$past(mem_rdata_i[DW-1:1])} && flags_o == $past(flags_o);
	endproperty
	a_rotr: assert property (p_rotr) else $error("right rotate wrong");

	property p_sub;
		taken && instr_i.op == OP_SUB_BORROW |=> work_o == DW'($past(work_o) - $past(mem_rdata_i)
			- {{(DW-1){1'b0}}, ~$past(flags_o.arith_spill_flag)});
	endproperty
	a_sub: assert property (p_sub) else $error("subtract with borrow wrong");

	property p_skip;
		taken && instr_i.op == OP_DEC_SKIP_ZERO && mem_rdata_i == DEC_STEP |=> discard_o
			&& !ready_o && mem_wdata_o == ZERO_BYTE ##1 ready_o && !discard_o;
	endproperty
	a_skip: assert property (p_skip) else $error("skip not taken");

	property p_no_skip;
		taken && instr_i.op == OP_DEC_SKIP_ZERO_WORK && mem_rdata_i != DEC_STEP |=> ready_o
			&& !discard_o && !mem_we_o;
	endproperty
	a_no_skip: assert property (p_no_skip) else $error("spurious skip");

	property p_sys_flags_hold;
		!sys_flags_we_i |=> flags_o.watchdog_timeout_flag == $past(flags_o.watchdog_timeout_flag)
			&& flags_o.power_down_flag == $past(flags_o.power_down_flag);
	endproperty
	a_sys_flags_hold: assert property (p_sys_flags_hold) else $error("system flag moved");

	c_skip: cover property (taken && instr_i.op == OP_DEC_SKIP_ZERO && dec_zero);
	c_back_from_irq: cover property (taken && instr_i.op == OP_BACK_FROM_IRQ);
	c_sub_borrow: cover property (taken && instr_i.op == OP_SUB_BORROW && !sub_full[DW]);
	c_rotr_cy: cover property (taken && instr_i.op == OP_ROTR_CY_WORK && m[0]);
endmodule : mrx_exec_unit
`default_nettype wire

/* rtl/mrx_pkg.sv */
// Package for the move, logic, rotate and skip slice of the 8-bit core
package mrx_pkg;
	localparam int DW = 8;
	localparam int PC_W = 12;
	localparam int NIB = 4;
	localparam logic [DW-1:0] WORK_RST = 8'h00;
	localparam logic [PC_W-1:0] PC_RST = 12'h000;
	localparam logic [PC_W-1:0] PC_STEP = 12'h001;
	localparam logic [PC_W-1:0] PC_SKIP_STEP = 12'h002;
	localparam logic [DW-1:0] DEC_STEP = 8'h01;
	localparam logic [DW-1:0] ZERO_BYTE = 8'h00;
	localparam logic IRQ_EN_RST = 1'b0;
	localparam logic IRQ_EN_SET = 1'b1;

	typedef enum logic [4:0] {
		OP_COPY_MEM_TO_WORK,
		OP_COPY_IMM_TO_WORK,
		OP_COPY_WORK_TO_MEM,
		OP_NO_OPERATION,
		OP_UNION_MEM,
		OP_UNION_IMM,
		OP_UNION_TO_MEM,
		OP_BACK_FROM_CALL,
		OP_BACK_FROM_CALL_IMM,
		OP_BACK_FROM_IRQ,
		OP_ROTL,
		OP_ROTL_WORK,
		OP_ROTL_CY,
		OP_ROTL_CY_WORK,
		OP_ROTR,
		OP_ROTR_WORK,
		OP_ROTR_CY,
		OP_ROTR_CY_WORK,
		OP_SUB_BORROW,
		OP_SUB_BORROW_MEM,
		OP_DEC_SKIP_ZERO,
		OP_DEC_SKIP_ZERO_WORK
	} mrx_op_t;

	typedef struct packed {
		mrx_op_t op;
		logic [DW-1:0] imm;
	} mrx_instr_t;

	typedef struct packed {
		logic watchdog_timeout_flag;
		logic power_down_flag;
		logic signed_wrap_flag;
		logic result_null_flag;
		logic half_carry_flag;
		logic arith_spill_flag;
	} mrx_flags_t;

	typedef struct packed {
		logic watchdog_timeout_flag;
		logic power_down_flag;
	} mrx_sysflags_t;

	localparam mrx_flags_t FLAGS_RST = '0;

	typedef enum logic {ST_RUN, ST_DUMMY} mrx_state_t;
endpackage : mrx_pkg

/* tb/mrx_exec_unit_test.sv */
// Self-checking bench for the move, logic, rotate and skip execution unit
`timescale 1ns/1ps
`default_nettype none
module mrx_exec_unit_test;
	import mrx_pkg::*;
	localparam mrx_op_t ROT [8] = '{OP_ROTL, OP_ROTL_WORK, OP_ROTL_CY, OP_ROTL_CY_WORK,
		OP_ROTR, OP_ROTR_WORK, OP_ROTR_CY, OP_ROTR_CY_WORK};
	localparam logic [7:0] SUB_W [3] = '{8'h00, 8'h80, 8'h15};
	localparam logic [7:0] SUB_M [3] = '{8'h01, 8'h00, 8'h15};
	logic mclk_i, sys_rst_i, issue_i, irq_en_clr_i, sys_flags_we_i, rdy;
	mrx_instr_t instr_i;
	mrx_sysflags_t sys_flags_i;
	logic [DW-1:0] mem_rdata, work_o, mem_wdata_o, ew;
	logic [PC_W-1:0] stack_top, pc_o, epc;
	logic ready_o, global_irq_enable_o, mem_we_o, stack_pop_o, discard_o;
	mrx_flags_t flags_o, ef;
	logic [3:0] addr;
	int miscompares = 0;
	int n_checks = 0;

	mrx_exec_unit i_mrx_exec_unit (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .issue_i(issue_i),
		.instr_i(instr_i), .mem_rdata_i(mem_rdata), .stack_top_i(stack_top),
		.irq_en_clr_i(irq_en_clr_i), .sys_flags_we_i(sys_flags_we_i), .sys_flags_i(sys_flags_i),
		.ready_o(ready_o), .work_o(work_o), .flags_o(flags_o),
		.global_irq_enable_o(global_irq_enable_o), .pc_o(pc_o), .mem_we_o(mem_we_o),
		.mem_wdata_o(mem_wdata_o), .stack_pop_o(stack_pop_o), .discard_o(discard_o));
	mrx_mem_stack i_mrx_mem_stack (.mclk_i(mclk_i), .issue_i(issue_i), .ready_i(ready_o),
		.addr_i(addr), .mem_we_i(mem_we_o), .mem_wdata_i(mem_wdata_o),
		.stack_pop_i(stack_pop_o), .mem_rdata_o(mem_rdata), .stack_top_o(stack_top));

	always #12.5 mclk_i = ~mclk_i;

	task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
		n_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] %0t ns: seen %h, expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic st();
		chk(12'(work_o), 12'(ew));
		chk(12'(flags_o), 12'(ef));
		chk(pc_o, epc);
	endtask : st

	task automatic io(input logic we, input logic [7:0] wd, input logic pop, input logic dis);
		chk(12'({mem_we_o, stack_pop_o, discard_o}), 12'({we, pop, dis}));
		if (we) begin
			chk(12'(mem_wdata_o), 12'(wd));
		end
	endtask : io

	// Issue for one cycle; returns in the answer cycle with ready captured
	task automatic exec(input mrx_op_t op, input logic [7:0] imm, input logic [3:0] a);
		@(negedge mclk_i);
		issue_i = 1'b1;
		instr_i = '{op: op, imm: imm};
		addr = a;
		@(negedge mclk_i);
		rdy = ready_o;
		issue_i = 1'b0;
	endtask : exec

	task automatic run(input mrx_op_t op, input logic [7:0] imm, input logic [3:0] a);
		exec(op, imm, a);
		epc += PC_STEP;
	endtask : run

	task automatic t_moves();
		@(negedge mclk_i);
		sys_flags_we_i = 1'b1;
		sys_flags_i = '{watchdog_timeout_flag: 1'b1, power_down_flag: 1'b1};
		@(negedge mclk_i);
		sys_flags_we_i = 1'b0;
		ef.watchdog_timeout_flag = 1'b1;
		ef.power_down_flag = 1'b1;
		run(OP_COPY_MEM_TO_WORK, 8'h00, 4'h3);
		ew = 8'ha5;
		st();
		run(OP_COPY_IMM_TO_WORK, 8'h5a, 4'h3);
		ew = 8'h5a;
		st();
		run(OP_COPY_WORK_TO_MEM, 8'h00, 4'h7);
		io(1'b1, 8'h5a, 1'b0, 1'b0);
		st();
		run(OP_NO_OPERATION, 8'hff, 4'h7);
		io(1'b0, 8'h00, 1'b0, 1'b0);
		st();
	endtask : t_moves

	task automatic t_union();
		run(OP_COPY_IMM_TO_WORK, 8'h00, 4'h3);
		ew = 8'h00;
		run(OP_UNION_IMM, 8'h00, 4'h3);
		ef.result_null_flag = 1'b1;
		st();
		run(OP_UNION_MEM, 8'h00, 4'h3);
		ew = 8'ha5;
		ef.result_null_flag = 1'b0;
		st();
		run(OP_UNION_TO_MEM, 8'h00, 4'h7);
		io(1'b1, 8'hff, 1'b0, 1'b0);
		st();
		run(OP_COPY_IMM_TO_WORK, 8'h00, 4'h3);
		ew = 8'h00;
		run(OP_UNION_TO_MEM, 8'h00, 4'h8);
		ef.result_null_flag = 1'b1;
		io(1'b1, 8'h00, 1'b0, 1'b0);
		st();
	endtask : t_union

	task automatic t_rot();
		logic [7:0] m, r;
		logic c;
		m = 8'hc3;
		for (int k = 0; k < 8; k++) begin
			run(ROT[k], 8'h00, 4'h9);
			c = ef.arith_spill_flag;
			case (k / 2)
				0: r = {m[6:0], m[7]};
				1: {c, r} = {m, ef.arith_spill_flag};
				2: r = {m[0], m[7:1]};
				default: {r, c} = {ef.arith_spill_flag, m};
			endcase
			io(!k[0], r, 1'b0, 1'b0);
			ew = k[0] ? r : ew;
			m = k[0] ? m : r;
			ef.arith_spill_flag = c;
			st();
		end
	endtask : t_rot

	task automatic t_sub();
		logic [7:0] w, m, r;
		logic c, h;
		for (int k = 0; k < 3; k++) begin
			w = SUB_W[k];
			m = SUB_M[k];
			i_mrx_mem_stack.mem[4'ha] = m;
			run(OP_COPY_IMM_TO_WORK, w, 4'ha);
			run(k == 2 ? OP_SUB_BORROW_MEM : OP_SUB_BORROW, 8'h00, 4'ha);
			{c, r} = {1'b0, w} + {1'b0, ~m} + 9'(ef.arith_spill_flag);
			h = ({1'b0, w[3:0]} + {1'b0, ~m[3:0]} + 5'(ef.arith_spill_flag)) > 5'h0f;
			ef.signed_wrap_flag = (w[7] != m[7]) && (r[7] != w[7]);
			ef.result_null_flag = r == 8'h00;
			ef.half_carry_flag = h;
			ef.arith_spill_flag = c;
			ew = k == 2 ? w : r;
			io(k == 2, r, 1'b0, 1'b0);
			st();
		end
	endtask : t_sub

	task automatic t_ret();
		i_mrx_mem_stack.stk = '{12'h123, 12'h456, 12'h789, 12'h000};
		i_mrx_mem_stack.sp = 2'd3;
		// Issue stays high into the second cycle, where it must be ignored
		@(negedge mclk_i);
		issue_i = 1'b1;
		instr_i = '{op: OP_BACK_FROM_CALL, imm: 8'h00};
		addr = 4'h0;
		@(negedge mclk_i);
		rdy = ready_o;
		instr_i = '{op: OP_COPY_IMM_TO_WORK, imm: 8'hff};
		epc = 12'h789;
		chk(12'(rdy), 12'h000);
		io(1'b0, 8'h00, 1'b1, 1'b0);
		st();
		@(negedge mclk_i);
		issue_i = 1'b0;
		st();
		exec(OP_BACK_FROM_CALL_IMM, 8'h3c, 4'h0);
		epc = 12'h456;
		ew = 8'h3c;
		io(1'b0, 8'h00, 1'b1, 1'b0);
		st();
		// Clear held during the interrupt return must lose to the set
		irq_en_clr_i = 1'b1;
		exec(OP_BACK_FROM_IRQ, 8'h00, 4'h0);
		epc = 12'h123;
		chk(12'(global_irq_enable_o), 12'h001);
		io(1'b0, 8'h00, 1'b1, 1'b0);
		st();
		irq_en_clr_i = 1'b1;
		@(negedge mclk_i);
		irq_en_clr_i = 1'b0;
		@(negedge mclk_i);
		chk(12'(global_irq_enable_o), 12'h000);
	endtask : t_ret

	task automatic t_skip();
		exec(OP_DEC_SKIP_ZERO, 8'h00, 4'h5);
		epc += PC_SKIP_STEP;
		chk(12'(rdy), 12'h000);
		io(1'b1, 8'h00, 1'b0, 1'b1);
		st();
		run(OP_DEC_SKIP_ZERO, 8'h00, 4'h6);
		chk(12'(rdy), 12'h001);
		io(1'b1, 8'h04, 1'b0, 1'b0);
		st();
		exec(OP_DEC_SKIP_ZERO_WORK, 8'h00, 4'h4);
		epc += PC_SKIP_STEP;
		ew = 8'h00;
		chk(12'(rdy), 12'h000);
		io(1'b0, 8'h00, 1'b0, 1'b1);
		st();
		run(OP_DEC_SKIP_ZERO_WORK, 8'h00, 4'h6);
		ew = 8'h03;
		chk(12'(rdy), 12'h001);
		io(1'b0, 8'h00, 1'b0, 1'b0);
		st();
	endtask : t_skip

	task automatic results();
		$display("checks %0d, miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : results

	initial begin
		#(2000 * 25);
		miscompares++;
		results();
	end

	initial begin
		mclk_i = 1'b0;
		sys_rst_i = 1'b1;
		issue_i = 1'b0;
		instr_i = '{op: OP_NO_OPERATION, imm: 8'h00};
		addr = 4'h0;
		irq_en_clr_i = 1'b0;
		sys_flags_we_i = 1'b0;
		sys_flags_i = '0;
		ew = WORK_RST;
		ef = FLAGS_RST;
		epc = PC_RST;
		i_mrx_mem_stack.mem = '{8'h00, 8'h00, 8'h00, 8'ha5, 8'h01, 8'h01, 8'h05, 8'h5a,
			8'h00, 8'hc3, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
		repeat (2) @(posedge mclk_i);
		@(negedge mclk_i);
		sys_rst_i = 1'b0;
		t_moves();
		t_union();
		t_rot();
		t_sub();
		t_ret();
		t_skip();
		results();
	end
endmodule : mrx_exec_unit_test
`default_nettype wire

/* tb/mrx_mem_stack.sv */
// Behavioural data memory and return-address stack beside the execution unit
`timescale 1ns/1ps
`default_nettype none
module mrx_mem_stack (
	input wire logic mclk_i,
	input wire logic issue_i,
	input wire logic ready_i,
	input wire logic [3:0] addr_i,
	input wire logic mem_we_i,
	input wire logic [mrx_pkg::DW-1:0] mem_wdata_i,
	input wire logic stack_pop_i,
	output logic [mrx_pkg::DW-1:0] mem_rdata_o,
	output logic [mrx_pkg::PC_W-1:0] stack_top_o
);
	import mrx_pkg::*;
	logic [DW-1:0] mem [16];
	logic [PC_W-1:0] stk [4];
	logic [1:0] sp;
	logic [3:0] wr_addr;
	// Outside an issue the lines show inverted data, never the last valid value
	assign mem_rdata_o = issue_i ? mem[addr_i] : ~mem[addr_i];
	assign stack_top_o = issue_i ? stk[sp - 2'd1] : ~stk[sp - 2'd1];
	// Write-back address is the one held when the instruction was taken
	always @(posedge mclk_i) begin
		if (issue_i && ready_i) begin
			wr_addr <= addr_i;
		end
		if (mem_we_i) begin
			mem[wr_addr] <= mem_wdata_i;
		end
		if (stack_pop_i) begin
			sp <= sp - 2'd1;
		end
	end
endmodule : mrx_mem_stack
`default_nettype wire
